// ==== hdl/hps_out_stage.sv ====
// Serial output stage of a two-slot hot-plug controller with test modes
//
// How it works
// [R1] Controller shifts slot data in serially first
// [R2] Holding registers copy the chain, drive pins
// [R3] Output latch clock updates power, bus, clock, lamps
// [R4] Reset latch clock updates only the reset outputs
// [R5] Slot failure forces reset, drops clock and bus
// [R6] Failure is main fault AND auxiliary fault
// [R7] Power valid rise, test low: normal, latch straps
// [R8] Normal mode drives both chain-out pins
// [R9] Test high, straps zero: NAND tree; else reserved
// [R10] Test high, strap one 0, zero 1: tri-state
// [R11] Test raised later gives run-time lamp test
// [R12] Lamp test: power lamp follows power on
// [R13] Lamp test: attention lamp follows failure
// [R14] NAND tree: all two-way pins float but input-chain-out
// [R15] Tester toggles inputs low-high in fixed order
// [R16] Tester toggles test last, high then low
// [R17] NAND tree drives NAND of inputs on input-chain-out
// [R18] Power valid rise initialises control and outputs
// [R19] After init lamps, bus, clock 1, reset 0
// [R20] Eight bits per slot, last slot shifted first
// [R21] Byte layout: power, clock, bus, reset, lamps
// [R22] Chain advances one bit per shift clock edge
// [R23] Latches capture on rising edge, then hold
`timescale 1ns/100ps
`include "hps_defs.svh"
module hps_out_stage #(
    parameter int SLOTS = `HPS_SLOTS,
    parameter int SBITS = `HPS_SLOT_BITS
) (
    input wire logic ref_clk_i, // 100 MHz system clock
    input wire logic srst_i, // Synchronous reset, active high
    input wire logic ce_i, // Clock enable, freezes state when low
    input wire logic output_chain_in_i, // Serial output data in
    input wire logic output_shift_clock_i, // Output shift clock pin
    input wire logic output_latch_clock_i, // Latch clock for controls and lamps
    input wire logic reset_latch_clock_i, // Latch clock for slot resets
    input wire logic power_valid_i, // Power valid pin
    input wire logic test_i, // Test pin
    input wire logic input_chain_in_i, // Serial input chain in
    input wire logic [SLOTS-1:0] main_fault_i, // Main power failure per slot
    input wire logic [SLOTS-1:0] aux_fault_i, // Auxiliary power failure per slot
    input wire logic output_chain_out_i, // Output chain out pin level, strap one
    output logic output_chain_out_o, // Output chain out drive
    output logic output_chain_out_oe_n_o, // Low while driven
    input wire logic input_chain_out_i, // Input chain out pin level, strap zero
    output logic input_chain_out_o, // Input chain out drive
    output logic input_chain_out_oe_n_o, // Low while driven
    output logic [SLOTS-1:0] power_on_o, // Slot power on, 1 = on
    output logic [SLOTS-1:0] slot_clock_gate_o, // Slot clock gate, 1 = enable
    output logic [SLOTS-1:0] bus_connect_o, // Bus connect, 1 = enable
    output logic [SLOTS-1:0] slot_reset_out_o, // Slot reset pin, 0 = asserted
    output logic [SLOTS-1:0] power_lamp_o, // Power lamp
    output logic [SLOTS-1:0] attention_lamp_o, // Attention lamp
    output logic slot_oe_n_o, // Low while slot pins are driven
    input wire logic [3:0] avs_address_i, // Avalon byte address
    input wire logic avs_read_i, // Avalon read
    input wire logic avs_write_i, // Avalon write
    input wire logic [31:0] avs_writedata_i, // Avalon write data
    input wire logic [3:0] avs_byteenable_i, // Avalon byte enables
    output logic [31:0] avs_readdata_o, // Avalon read data
    output logic avs_waitrequest_o // Avalon wait request
);
    localparam int SRW = SLOTS * SBITS; // Chain length in this device

    hps_pin_if #(.W(`HPS_NPIN)) pins (); // Synchronised pin bundle
    hps_pkg::hps_mode_t mode; // Current operating mode
    logic [SRW-1:0] chain; // Output shift register
    hps_pkg::hps_slot_t hold [SLOTS]; // Holding registers
    logic [1:0] strap; // Latched straps {one, zero}
    logic ltest; // Software lamp test request
    logic [SLOTS-1:0] fail; // Combined slot failure
    logic pv_rise; // Power valid rising edge
    logic osc_rise; // Shift clock rising edge
    logic olc_rise; // Output latch clock rising edge
    logic rlc_rise; // Reset latch clock rising edge
    logic run_test; // Run-time lamp test active
    logic [6:0] nand_in; // Inputs combined in the NAND tree
    logic acc; // Bus access in the answer cycle

    // All pins cross into the clock domain before use
    hps_sync #(.W(`HPS_NPIN)) u_sync (
        .ref_clk_i (ref_clk_i),
        .srst_i (srst_i),
        .ce_i (ce_i),
        .raw_i ({aux_fault_i, main_fault_i, input_chain_in_i, input_chain_out_i,
                 output_chain_out_i, test_i, power_valid_i, reset_latch_clock_i,
                 output_latch_clock_i, output_shift_clock_i, output_chain_in_i}),
        .pins (pins)
    );

    // Slot byte selector, slot A sits at the top of the chain
    function automatic logic [SBITS-1:0] slot_byte(input logic [SRW-1:0] c, input int s);
        slot_byte = c[(SLOTS - 1 - s) * SBITS +: SBITS]; // [R20]
    endfunction

    assign pv_rise = pins.rise[`HPS_P_PV];
    assign osc_rise = pins.rise[`HPS_P_OSC];
    assign olc_rise = pins.rise[`HPS_P_OLC];
    assign rlc_rise = pins.rise[`HPS_P_RLC];

    // Failure per slot; only both supplies failing counts
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_fail
            assign fail[g] = pins.level[`HPS_P_MF0 + g] & pins.level[`HPS_P_AF0 + g]; // [R6]
        end
    endgenerate

    // Test raised while already in normal mode, or asked by software
    assign run_test = (mode == hps_pkg::HPS_NORMAL) & (pins.level[`HPS_P_TEST] | ltest); // [R11]

    // Chain inputs that feed the NAND tree, in tester order
    assign nand_in = {pins.level[`HPS_P_TEST], pins.level[`HPS_P_RLC], pins.level[`HPS_P_OLC],
                      pins.level[`HPS_P_OSC], pins.level[`HPS_P_OCI], pins.level[`HPS_P_OCO],
                      pins.level[`HPS_P_ICI]}; // [R15] [R16]

    // Mode chosen at the power valid edge from test and straps
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            mode <= hps_pkg::HPS_OFF;
        end else if (ce_i) begin
            if (!pins.level[`HPS_P_PV]) begin
                mode <= hps_pkg::HPS_OFF;
            end else if (pv_rise) begin
                if (!pins.level[`HPS_P_TEST]) begin
                    mode <= hps_pkg::HPS_NORMAL; // [R7]
                end else if (pins.level[`HPS_P_OCO]) begin
                    mode <= hps_pkg::HPS_RSVD; // [R9]
                end else if (pins.level[`HPS_P_ICO]) begin
                    mode <= hps_pkg::HPS_TRI; // [R10]
                end else begin
                    mode <= hps_pkg::HPS_NAND; // [R9]
                end
            end
        end
    end

    // Straps sampled from the chain-out pins at the normal-mode edge
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            strap <= 2'h0;
        end else if (ce_i && pv_rise && !pins.level[`HPS_P_TEST]) begin
            strap <= {pins.level[`HPS_P_OCO], pins.level[`HPS_P_ICO]}; // [R7]
        end
    end

    // Shift register; new bits enter at the top so the first bit lands at bit 0
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            chain <= '0;
        end else if (ce_i) begin
            if (pv_rise) begin
                chain <= '0; // [R18]
            end else if (osc_rise && mode == hps_pkg::HPS_NORMAL) begin
                chain <= {pins.level[`HPS_P_OCI], chain[SRW-1:1]}; // [R1] [R22]
            end
        end
    end

    // Holding registers: two latch clocks, init on power valid, fault override last
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            for (int s = 0; s < SLOTS; s++) begin
                hold[s] <= `HPS_INIT_SLOT;
            end
        end else if (ce_i) begin
            for (int s = 0; s < SLOTS; s++) begin
                if (pv_rise) begin
                    hold[s] <= `HPS_INIT_SLOT; // [R18] [R19]
                end else if (mode == hps_pkg::HPS_NORMAL) begin
                    if (olc_rise) begin
                        hold[s].pwr <= slot_byte(chain, s)[`HPS_B_PWR]; // [R2] [R3] [R21] [R23]
                        hold[s].clk <= slot_byte(chain, s)[`HPS_B_CLK]; // [R3]
                        hold[s].bus <= slot_byte(chain, s)[`HPS_B_BUS]; // [R3]
                        hold[s].plmp <= slot_byte(chain, s)[`HPS_B_PLMP]; // [R3]
                        hold[s].almp <= slot_byte(chain, s)[`HPS_B_ALMP]; // [R3]
                    end
                    if (rlc_rise) begin
                        hold[s].rst <= slot_byte(chain, s)[`HPS_B_RST]; // [R4] [R23]
                    end
                end
                // Placed last so a fault wins over any latch edge in the same cycle
                if (fail[s]) begin
                    hold[s].rst <= 1'b0; // [R5]
                    hold[s].clk <= 1'b0; // [R5]
                    hold[s].bus <= 1'b0; // [R5]
                end
            end
        end
    end

    // Slot pins, registered; lamps swap source in run-time test
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            power_on_o <= '0;
            slot_clock_gate_o <= '1;
            bus_connect_o <= '1;
            slot_reset_out_o <= '0;
            power_lamp_o <= '1;
            attention_lamp_o <= '1;
        end else if (ce_i) begin
            for (int s = 0; s < SLOTS; s++) begin
                power_on_o[s] <= hold[s].pwr; // [R2]
                slot_clock_gate_o[s] <= hold[s].clk;
                bus_connect_o[s] <= hold[s].bus;
                slot_reset_out_o[s] <= hold[s].rst;
                power_lamp_o[s] <= run_test ? hold[s].pwr : hold[s].plmp; // [R12]
                attention_lamp_o[s] <= run_test ? fail[s] : hold[s].almp; // [R13]
            end
        end
    end

    // Chain-out pins: serial data in normal, NAND result in tree test
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            output_chain_out_o <= 1'b0;
            output_chain_out_oe_n_o <= 1'b1;
            input_chain_out_o <= 1'b0;
            input_chain_out_oe_n_o <= 1'b1;
            slot_oe_n_o <= 1'b0;
        end else if (ce_i) begin
            output_chain_out_o <= chain[0]; // [R22]
            // The input scan chain itself is outside this block; pass its serial data on
            input_chain_out_o <= (mode == hps_pkg::HPS_NAND) ? ~&nand_in : pins.level[`HPS_P_ICI]; // [R17]
            output_chain_out_oe_n_o <= (mode != hps_pkg::HPS_NORMAL); // [R8] [R14]
            input_chain_out_oe_n_o <= !(mode == hps_pkg::HPS_NORMAL || mode == hps_pkg::HPS_NAND); // [R8]
            // Reserved mode floats too, the safest reading of an unused combination
            slot_oe_n_o <= (mode == hps_pkg::HPS_NAND || mode == hps_pkg::HPS_TRI ||
                            mode == hps_pkg::HPS_RSVD); // [R10] [R14]
        end
    end

    // Avalon slave: one wait cycle, then answer; acc marks the answer cycle
    assign acc = (avs_read_i | avs_write_i) & !avs_waitrequest_o;

    // Wait request drops for one cycle after each new request
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (ce_i) begin
            avs_waitrequest_o <= !((avs_read_i | avs_write_i) & avs_waitrequest_o);
        end
    end

    // Read data is prepared with the wait drop so it stands at the taking edge
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            avs_readdata_o <= '0;
        end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
            case (avs_address_i)
                `HPS_REG_STATUS: avs_readdata_o <= {24'h0, run_test, fail, strap, mode};
                `HPS_REG_HOLD: avs_readdata_o <= {18'h0, hold[1], 2'h0, hold[0]};
                `HPS_REG_CTRL: avs_readdata_o <= {31'h0, ltest};
                default: avs_readdata_o <= '0; // Unmapped reads zero
            endcase
        end
    end

    // Control register, written at the answer edge
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ltest <= 1'b0;
        end else if (ce_i && acc && avs_write_i && avs_address_i == `HPS_REG_CTRL && avs_byteenable_i[0]) begin
            ltest <= avs_writedata_i[`HPS_CTRL_LTEST];
        end
    end

    default clocking dcb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    shift_advance_a: assert property (ce_i && osc_rise && !pv_rise && mode == hps_pkg::HPS_NORMAL
        |=> chain == {$past(pins.level[`HPS_P_OCI]), $past(chain[SRW-1:1])}) // [R22]
        else $error("chain did not shift one bit");
    output_latch_only_a: assert property ($changed(hold[0].pwr) |-> $past(ce_i && (olc_rise || pv_rise))) // [R3]
        else $error("power on changed without latch edge");
    reset_latch_only_a: assert property ($rose(hold[0].rst) |-> $past(ce_i && rlc_rise)) // [R4]
        else $error("reset released without reset latch edge");
    fault_force_a: assert property (ce_i && fail[0]
        |=> !hold[0].rst && !hold[0].clk && !hold[0].bus) // [R5]
        else $error("fault did not force slot");
    fault_pin_a: assert property ((ce_i && fail[0]) [*3] |-> !bus_connect_o[0] && !slot_reset_out_o[0]) // [R6]
        else $error("fault did not reach slot pins");
    strap_mode_a: assert property (ce_i && pv_rise && !pins.level[`HPS_P_TEST] && pins.level[`HPS_P_PV]
        |=> mode == hps_pkg::HPS_NORMAL && strap == $past({pins.level[`HPS_P_OCO], pins.level[`HPS_P_ICO]})) // [R7]
        else $error("normal entry or strap latch wrong");
    chain_drive_a: assert property (ce_i && mode == hps_pkg::HPS_NORMAL
        |=> !output_chain_out_oe_n_o && !input_chain_out_oe_n_o) // [R8]
        else $error("chain-out pins not driven");
    nand_out_a: assert property (ce_i && mode == hps_pkg::HPS_NAND
        |=> input_chain_out_o == !(&$past(nand_in)) && output_chain_out_oe_n_o && slot_oe_n_o) // [R17]
        else $error("NAND tree output wrong");
    tri_all_a: assert property (ce_i && mode == hps_pkg::HPS_TRI
        |=> output_chain_out_oe_n_o && input_chain_out_oe_n_o && slot_oe_n_o) // [R10]
        else $error("pin driven in tri-state mode");
    lamp_test_a: assert property (ce_i && run_test
        |=> power_lamp_o[0] == $past(hold[0].pwr) && attention_lamp_o[0] == $past(fail[0])) // [R12]
        else $error("run-time lamp test wrong");
    init_state_a: assert property (ce_i && pv_rise && !fail[0] |=> hold[0] == `HPS_INIT_SLOT ##1
        !ce_i || (power_lamp_o[0] && bus_connect_o[0] && !slot_reset_out_o[0])) // [R19]
        else $error("init state wrong");
    bus_answer_a: assert property (ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("bus did not answer in one cycle");

    normal_entry_c: cover property (ce_i && pv_rise ##1 mode == hps_pkg::HPS_NORMAL);
    fault_hit_c: cover property (ce_i && fail[0] && hold[0].bus);
    nand_run_c: cover property (mode == hps_pkg::HPS_NAND && $changed(input_chain_out_o));
    lamp_test_c: cover property (run_test && $changed(power_lamp_o[0]));
endmodule

// ==== hdl/hps_defs.svh ====
// Constants for the hot-plug slot output stage: layout, offsets, reset values
`ifndef HPS_DEFS_SVH
`define HPS_DEFS_SVH

// Slot count and bits shifted per slot
`define HPS_SLOTS 2
`define HPS_SLOT_BITS 8

// Field positions inside one slot byte
`define HPS_B_PWR 0
`define HPS_B_CLK 1
`define HPS_B_BUS 2
`define HPS_B_RST 3
`define HPS_B_PLMP 4
`define HPS_B_ALMP 5

// Holding value after init: lamps, bus and clock at 1, reset and power at 0
`define HPS_INIT_SLOT 6'h36

// Index of each pin in the synchronised pin vector
`define HPS_P_OCI 0
`define HPS_P_OSC 1
`define HPS_P_OLC 2
`define HPS_P_RLC 3
`define HPS_P_PV 4
`define HPS_P_TEST 5
`define HPS_P_OCO 6
`define HPS_P_ICO 7
`define HPS_P_ICI 8
`define HPS_P_MF0 9
`define HPS_P_AF0 11
`define HPS_NPIN 13

// Register byte offsets
`define HPS_REG_STATUS 4'h0
`define HPS_REG_HOLD 4'h4
`define HPS_REG_CTRL 4'h8

// Control register field
`define HPS_CTRL_LTEST 0

`endif

// ==== hdl/hps_pkg.sv ====
// Types shared by the hot-plug slot output stage
package hps_pkg;

    // Operating mode chosen at the power valid rising edge
    typedef enum logic [2:0] {
        HPS_OFF,
        HPS_NORMAL,
        HPS_NAND,
        HPS_TRI,
        HPS_RSVD
    } hps_mode_t;

    // Holding register of one slot, bit 0 is power on
    typedef struct packed {
        logic almp;
        logic plmp;
        logic rst;
        logic bus;
        logic clk;
        logic pwr;
    } hps_slot_t;

endpackage

// ==== hdl/hps_pin_if.sv ====
// Synchronised pin levels and rising edges passed to the output stage
`timescale 1ns/100ps
interface hps_pin_if #(
    parameter int W = 13
);
    logic [W-1:0] level; // Synchronised pin levels
    logic [W-1:0] rise;  // One-cycle rising edge markers

    modport src (output level, rise);
    modport dst (input level, rise);
endinterface

// ==== hdl/hps_sync.sv ====
// Two-flop synchroniser with rising edge detection for a vector of pins
`timescale 1ns/100ps
module hps_sync #(
    parameter int W = 13
) (
    input wire logic ref_clk_i,       // System clock
    input wire logic srst_i,          // Synchronous reset, active high
    input wire logic ce_i,            // Clock enable
    input wire logic [W-1:0] raw_i,   // Asynchronous pin levels
    hps_pin_if.src pins               // Synchronised levels and edges
);
    logic [W-1:0] meta; // First stage, read only by the second stage
    logic [W-1:0] stab; // Second stage
    logic [W-1:0] prev; // Previous stable level for edge detection

    // Two stages, then one more to find edges; reset holds all low
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta <= '0;
            stab <= '0;
            prev <= '0;
        end else if (ce_i) begin
            meta <= raw_i;
            stab <= meta;
            prev <= stab;
        end
    end

    assign pins.level = stab;
    assign pins.rise = stab & ~prev;
endmodule

// ==== sim/hps_ctl_model.sv ====
// Hot-plug controller model: serial chain and latch clocks
`timescale 1ns/100ps
module hps_ctl_model (
    input wire logic ref_clk_i, // System clock, paces the link timing
    output logic sdata_o,       // Serial data toward the output chain input
    output logic sclk_o,        // Output shift clock, still between frames
    output logic olc_o,         // Output latch clock
    output logic rlc_o          // Reset latch clock
);
    // All lines idle low until a frame starts
    initial begin
        sdata_o = 1'b0;
        sclk_o = 1'b0;
        olc_o = 1'b0;
        rlc_o = 1'b0;
    end
    // Shift 16 bits, bit 0 first, 90 ns a bit
    task automatic shift16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk_i);
            sdata_o <= v[i];
            repeat (4) @(posedge ref_clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            sclk_o <= 1'b0;
        end
        // Released data line shows the inverse, never a stale copy
        sdata_o <= ~v[15];
    endtask
    // One latch pulse, 40 ns high, then 40 ns low
    task automatic latch(input bit rst);
        @(posedge ref_clk_i);
        if (rst) begin
            rlc_o <= 1'b1;
        end else begin
            olc_o <= 1'b1;
        end
        repeat (4) @(posedge ref_clk_i);
        rlc_o <= 1'b0;
        olc_o <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // One line for the NAND walk, called on a rising edge
    task automatic set_line(input int i, input logic v);
        case (i)
            0: sdata_o <= v;
            1: sclk_o <= v;
            2: olc_o <= v;
            default: rlc_o <= v;
        endcase
    endtask
endmodule

// ==== sim/test_hps_out_stage.sv ====
// Self-checking bench for the hot-plug slot output stage
`timescale 1ns/100ps
`include "hps_defs.svh"
module test_hps_out_stage;
    logic ref_clk_i = 1'b0; // System clock
    logic srst_i = 1'b1; // Reset, held at start
    logic ce_i = 1'b1; // Clock enable
    logic [3:0] avs_byteenable_i = 4'hf; // Byte enables
    logic power_valid_i = 1'b0; // Power valid pin
    logic test_i = 1'b0; // Test pin
    logic input_chain_in_i = 1'b0; // Input chain serial in
    logic strap1 = 1'b0; // Bench level on output chain out pin
    logic strap0 = 1'b0; // Bench level on input chain out pin
    logic [1:0] main_fault_i = 2'h0; // Main failure per slot
    logic [1:0] aux_fault_i = 2'h0; // Auxiliary failure per slot
    logic [3:0] avs_address_i = 4'h0; // Bus address
    logic avs_read_i = 1'b0; // Bus read
    logic avs_write_i = 1'b0; // Bus write
    logic [31:0] avs_writedata_i = 32'h0; // Bus write data
    logic [31:0] avs_readdata_o; // Bus read data
    logic avs_waitrequest_o; // Bus wait
    logic sdata, sclk, olc, rlc; // Partner lines
    logic oco, oco_oe_n, ico, ico_oe_n, slot_oe_n; // Chain drives and enables
    logic [1:0] pwr, clk, bus, rst, plmp, almp; // Slot pins
    wire logic oco_pin = oco_oe_n ? strap1 : oco; // Pin level, strap when released
    wire logic ico_pin = ico_oe_n ? strap0 : ico; // Pin level, strap when released
    int bad_count = 0; // Mismatches
    int comparisons = 0; // Comparisons made
    int seed = 98203; // Random seed
    int hold[2]; // Model of each slot holding register
    int fail, rtt, mode, straps; // Model of status fields
    logic [31:0] rd; // Last read data

    // 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;

    hps_ctl_model hps_ctl_model_inst (.ref_clk_i(ref_clk_i), .sdata_o(sdata), .sclk_o(sclk), .olc_o(olc),
        .rlc_o(rlc));
    hps_out_stage hps_out_stage_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .output_chain_in_i(sdata), .output_shift_clock_i(sclk), .output_latch_clock_i(olc),
        .reset_latch_clock_i(rlc), .power_valid_i(power_valid_i), .test_i(test_i),
        .input_chain_in_i(input_chain_in_i), .main_fault_i(main_fault_i), .aux_fault_i(aux_fault_i),
        .output_chain_out_i(oco_pin), .output_chain_out_o(oco), .output_chain_out_oe_n_o(oco_oe_n),
        .input_chain_out_i(ico_pin), .input_chain_out_o(ico), .input_chain_out_oe_n_o(ico_oe_n),
        .power_on_o(pwr), .slot_clock_gate_o(clk), .bus_connect_o(bus), .slot_reset_out_o(rst),
        .power_lamp_o(plmp), .attention_lamp_o(almp), .slot_oe_n_o(slot_oe_n),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o));

    // Verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask
    // Let n edges pass, sample at the falling edge
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
    // One Avalon access, held until waitrequest is seen low
    task automatic bus_op(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        @(posedge ref_clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    // Drive one NAND tree input
    task automatic drive(input int i, input logic v);
        @(posedge ref_clk_i);
        if (i == 0) input_chain_in_i <= v;
        else if (i == 1) strap1 <= v;
        else hps_ctl_model_inst.set_line(i - 2, v);
    endtask
    // Slot pins and both registers against the model
    task automatic chk_all();
        logic [5:0] e;
        settle(8);
        for (int s = 0; s < 2; s++) begin
            e = hold[s][5:0];
            if (rtt != 0) e = {fail[s], e[0], e[3:0]};
            check("slot pins", {almp[s], plmp[s], rst[s], bus[s], clk[s], pwr[s]}, e);
        end
        bus_op(1'b0, `HPS_REG_HOLD, 32'h0, rd);
        check("hold", rd, hold[1] << 8 | hold[0]);
        bus_op(1'b0, `HPS_REG_STATUS, 32'h0, rd);
        check("status", rd, mode | straps << 3 | fail << 5 | rtt << 7);
    endtask
    // Power valid cycle with test and straps
    task automatic power_up(input logic t, s1, s0, input int m, input logic [2:0] oe);
        @(posedge ref_clk_i);
        power_valid_i <= 1'b0;
        test_i <= t;
        strap1 <= s1;
        strap0 <= s0;
        settle(6);
        @(posedge ref_clk_i);
        power_valid_i <= 1'b1;
        mode = m;
        straps = {s1, s0};
        hold[0] = `HPS_INIT_SLOT;
        hold[1] = `HPS_INIT_SLOT;
        settle(8);
        check("enables", {slot_oe_n, oco_oe_n, ico_oe_n}, oe);
        if (m == 1) begin
            chk_all();
        end else begin
            bus_op(1'b0, `HPS_REG_STATUS, 32'h0, rd);
            check("mode", rd[2:0], m);
        end
    endtask

    // Watchdog, well past a normal run
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        logic [15:0] v;
        fail = 0;
        rtt = 0;
        repeat (4) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        power_up(1'b1, 1'b0, 1'b1, 3, 3'h7);
        power_up(1'b1, 1'b1, 1'($random(seed)), 4, 3'h7);
        power_up(1'b1, 1'b0, 1'b0, 2, 3'h6);
        // NAND walk: all high gives 0; test goes last
        for (int i = 0; i < 6; i++) drive(i, 1'b1);
        settle(5);
        check("nand", ico, 32'h0);
        for (int i = 0; i < 6; i++) begin
            drive(i, 1'b0);
            settle(5);
            check("nand", ico, 32'h1);
            drive(i, 1'b1);
            settle(5);
            check("nand", ico, 32'h0);
        end
        @(posedge ref_clk_i);
        test_i <= 1'b0;
        settle(5);
        check("nand", ico, 32'h1);
        for (int i = 0; i < 6; i++) drive(i, 1'b0);
        power_up(1'b0, 1'($random(seed)), 1'($random(seed)), 1, 3'h0);
        drive(0, 1'($random(seed)));
        settle(6);
        check("chain pass", ico_pin, input_chain_in_i);
        // Two frames, output latch then reset latch
        repeat (2) begin
            v = 16'($random(seed));
            hps_ctl_model_inst.shift16(v);
            settle(4);
            check("chain out", oco_pin, v[0]);
            hps_ctl_model_inst.latch(1'b0);
            for (int s = 0; s < 2; s++) hold[s] = (hold[s] & 8) | ((v >> (8 - 8 * s)) & 6'h37);
            chk_all();
            hps_ctl_model_inst.latch(1'b1);
            for (int s = 0; s < 2; s++) hold[s] = (hold[s] & 6'h37) | ((v >> (8 - 8 * s)) & 8);
            chk_all();
        end
        // Software lamp test, unmapped reads zero
        bus_op(1'b1, `HPS_REG_CTRL, 32'h1, rd);
        bus_op(1'b0, `HPS_REG_CTRL, 32'h0, rd);
        check("ctrl", rd, 32'h1);
        bus_op(1'b1, 4'hc, 32'hffffffff, rd);
        bus_op(1'b0, 4'hc, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        rtt = 1;
        chk_all();
        bus_op(1'b1, `HPS_REG_CTRL, 32'h0, rd);
        @(posedge ref_clk_i);
        test_i <= 1'b1;
        chk_all();
        // Failure needs both indications
        @(posedge ref_clk_i);
        main_fault_i <= 2'h1;
        aux_fault_i <= 2'h2;
        chk_all();
        @(posedge ref_clk_i);
        aux_fault_i <= 2'h3;
        fail = 1;
        hold[0] = hold[0] & 6'h31;
        chk_all();
        // All ones latched while slot A fails: failure wins
        hps_ctl_model_inst.shift16(16'hffff);
        hps_ctl_model_inst.latch(1'b0);
        hps_ctl_model_inst.latch(1'b1);
        hold[0] = 6'h31;
        hold[1] = 6'h3f;
        chk_all();
        @(posedge ref_clk_i);
        main_fault_i <= 2'h0;
        aux_fault_i <= 2'h0;
        test_i <= 1'b0;
        fail = 0;
        rtt = 0;
        power_up(1'b0, 1'b1, 1'b0, 1, 3'h0);
        stop_test();
    end
endmodule
